// file: src/sram_ecc_regs.svh
// widths, reset values and code layout for the sram integrity wrapper
`ifndef SRAM_ECC_REGS_SVH
`define SRAM_ECC_REGS_SVH
`define DATA_W 16
`define ADDR_W 12
`define CHK_W 5
`define CODE_W 21
`define PAR_W 3
`define CNT_W 16
`define CNT_RST 16'h0000
`define CNT_MAX 16'hffff
`define PAR_LO_BIT 0
`define PAR_HI_BIT 1
`define PAR_ADDR_BIT 2
`endif

// file: src/sram_ecc_pkg.sv
// types shared by the sram integrity wrapper and its codec
package sram_ecc_pkg;
`include "sram_ecc_regs.svh"
  typedef struct packed {
    logic write;
    logic scrub;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } req_t;
  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic err;
    logic corrected;
  } rsp_t;
  typedef struct packed {
    logic pbit;
    logic [`CHK_W-1:0] check;
    logic [`DATA_W-1:0] data;
  } mem_word_t;
  typedef enum logic [1:0] {
    st_idle, st_wait, st_check, st_finish
  } state_t;
endpackage : sram_ecc_pkg

// file: src/ecc_parity_codec.sv
// check-bit generator and checker for secded or parity words
`timescale 1ns/1ps
`include "sram_ecc_regs.svh"
module ecc_parity_codec
  import sram_ecc_pkg::*;
(
  input wire logic ecc_mode,
  input wire logic [`ADDR_W-1:0] addr,
  input wire mem_word_t word,
  output mem_word_t coded,
  output logic [`CHK_W-1:0] syndrome,
  output logic [`DATA_W-1:0] fixed_data,
  output logic single_err,
  output logic fatal_err
);
  logic [`CHK_W-1:0] ham;
  logic [`PAR_W-1:0] par;
  logic overall;
  wire syn_zero = (syndrome == '0);
  wire syn_in_range = (32'(syndrome) <= `CODE_W);

  // hamming bits over positions 1..21, data at non-power positions
  always_comb begin
    int d;
    d = 0;
    ham = '0;
    for (int p = 1; p <= `CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < `CHK_W; k++) begin
          if (p[k]) begin
            ham[k] = ham[k] ^ word.data[d];
          end
        end
        d++;
      end
    end
  end

  // data and address parity kept apart
  assign par[`PAR_LO_BIT] = ^word.data[7:0];
  assign par[`PAR_HI_BIT] = ^word.data[15:8];
  assign par[`PAR_ADDR_BIT] = ^addr;

  // regenerated code word; extra bit folds address into the secded check
  assign coded.data = word.data;
  assign coded.check = ecc_mode ? ham : {2'b00, par};
  assign coded.pbit = ecc_mode & (^word.data ^ ^ham ^ ^addr);
  assign syndrome = coded.check ^ word.check;
  assign overall = ^word.data ^ ^word.check ^ word.pbit ^ ^addr;

  // classify: ecc single flips outside the extra bit are corrected; other detected errors are fatal
  assign single_err = ecc_mode & overall & !syn_zero & syn_in_range;
  assign fatal_err = ecc_mode ?
    ((!syn_zero & !overall) | (overall & (syn_zero | !syn_in_range))) :
    !syn_zero;

  // flip the data bit that the syndrome points at
  always_comb begin
    int d;
    d = 0;
    fixed_data = word.data;
    for (int p = 1; p <= `CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (single_err && 32'(syndrome) == p) begin
          fixed_data[d] = ~word.data[d];
        end
        d++;
      end
    end
  end
endmodule : ecc_parity_codec

// file: src/sram_wrapper_ecc_parity.sv
// sram wrapper with secded or parity check on data and address
//
// Overview of operation
// - each 16-bit word stored as a 22-bit secded word (5 hamming bits plus an extra bit), data and address checked
// - ecc read data is checked at memory output before it is returned
// - correctable errors return fixed data and bump the corrected count
// - corrected count crossing the threshold raises an ordinary interrupt
// - uncorrectable ecc error raises nmi and sets the error status pin
// - ecc logic works straight out of reset, nothing to set up
// - secded corrects any single flip outside the extra bit (that one is fatal) and flags any double flip
// - parity arrays keep a 3-bit code, data and address separately
// - parity read data is checked before it is returned
// - parity check catches any single-bit flip except one in the extra bit, which it ignores
// - parity error raises nmi and sets the error status pin
// - parity logic works straight out of reset, nothing to set up
// - scrub reads go through the same checker as normal reads
// - an ecc single-bit error outside the extra bit is written back corrected
`timescale 1ns/1ps
`include "sram_ecc_regs.svh"
module sram_wrapper_ecc_parity
  import sram_ecc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic ecc_mode,
  input wire logic [`CNT_W-1:0] corr_threshold,
  input wire logic count_clear,
  input wire logic error_clear,
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output rsp_t rsp,
  output logic mem_en,
  output logic mem_we,
  output logic [`ADDR_W-1:0] mem_addr,
  output mem_word_t mem_wdata,
  input wire mem_word_t mem_rdata,
  output logic [`CNT_W-1:0] corr_count,
  output logic corr_irq,
  output logic nmi,
  output logic error_status_pin
);
  state_t state;
  state_t next_state;
  req_t cur;
  mem_word_t enc_in;
  mem_word_t enc_word;
  logic [`DATA_W-1:0] fixed_data;
  logic single_err;
  logic fatal_err;

  // handshake and phase decode
  wire take = (state == st_idle) & req_valid & req_ready;
  wire in_check = (state == st_check);
  wire do_correct = in_check & single_err;
  wire do_fatal = in_check & fatal_err;
  wire writeback = do_correct;
  wire count_full = (corr_count == `CNT_MAX);
  wire bump = do_correct & !count_full;
  wire crossing = bump & (corr_count == corr_threshold);

  // next values of the registered outputs
  wire next_ready = (next_state == st_idle);
  wire next_mem_en = take | writeback;
  wire next_mem_we = (take & req.write) | writeback;
  wire next_rsp_valid = in_check;
  wire next_pin = do_fatal | (error_status_pin & !error_clear);
  wire [`CNT_W-1:0] next_count_up = corr_count + 16'h0001;

  // encoder input: new write data, or the corrected word for write-back
  assign enc_in.pbit = 1'b0;
  assign enc_in.check = '0;
  assign enc_in.data = in_check ? fixed_data : req.wdata;
  wire [`ADDR_W-1:0] enc_addr = in_check ? cur.addr : req.addr;

  // generator for writes and write-back
  ecc_parity_codec encoder (
    .ecc_mode(ecc_mode),
    .addr(enc_addr),
    .word(enc_in),
    .coded(enc_word),
    .syndrome(),
    .fixed_data(),
    .single_err(),
    .fatal_err()
  );

  // checker sitting right at the memory output
  ecc_parity_codec decoder (
    .ecc_mode(ecc_mode),
    .addr(cur.addr),
    .word(mem_rdata),
    .coded(),
    .syndrome(),
    .fixed_data(fixed_data),
    .single_err(single_err),
    .fatal_err(fatal_err)
  );

  // sequence: take, memory cycle, check, finish
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (take) begin
          next_state = req.write ? st_finish : st_wait;
        end
      end
      st_wait: next_state = st_check;
      st_check: next_state = writeback ? st_finish : st_idle;
      st_finish: next_state = st_idle;
    endcase
  end

  // state register; checking runs from reset
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // request held for the check and the write-back
  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
    end else if (take) begin
      cur <= req;
    end
  end

  // ready is dropped while a transfer is in flight
  always_ff @(posedge clock) begin
    if (srst) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= next_ready;
    end
  end

  // memory strobes: one cycle per access, write-back after a fix
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_en <= 1'b0;
      mem_we <= 1'b0;
    end else begin
      mem_en <= next_mem_en;
      mem_we <= next_mem_we;
    end
  end

  // memory address follows the taken request
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_addr <= '0;
    end else if (take) begin
      mem_addr <= req.addr;
    end
  end

  // coded word for a write or a write-back
  always_ff @(posedge clock) begin
    if (srst) begin
      mem_wdata <= '0;
    end else if (next_mem_we) begin
      mem_wdata <= enc_word;
    end
  end

  // answer strobe only after the check has resolved
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= next_rsp_valid;
    end
  end

  // answer payload, held until the next answer
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp <= '0;
    end else if (next_rsp_valid) begin
      rsp.data <= fixed_data;
      rsp.err <= fatal_err;
      rsp.corrected <= single_err;
    end
  end

  // corrected count, saturating; an increment beats a clear
  always_ff @(posedge clock) begin
    if (srst) begin
      corr_count <= `CNT_RST;
    end else if (bump) begin
      corr_count <= next_count_up;
    end else if (count_clear) begin
      corr_count <= `CNT_RST;
    end
  end

  // one-cycle interrupt pulses
  always_ff @(posedge clock) begin
    if (srst) begin
      corr_irq <= 1'b0;
      nmi <= 1'b0;
    end else begin
      corr_irq <= crossing;
      nmi <= do_fatal;
    end
  end

  // sticky error pin; a new error beats a clear
  always_ff @(posedge clock) begin
    if (srst) begin
      error_status_pin <= 1'b0;
    end else begin
      error_status_pin <= next_pin;
    end
  end
endmodule : sram_wrapper_ecc_parity

// file: testbench/sram_wrapper_ecc_parity_props.sv
// port assertions for the sram integrity wrapper
`timescale 1ns/1ps
module sram_wrapper_ecc_parity_props
  import sram_ecc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [15:0] corr_threshold,
  input wire logic error_clear,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire rsp_t rsp,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic [11:0] mem_addr,
  input wire logic [15:0] corr_count,
  input wire logic corr_irq,
  input wire logic nmi,
  input wire logic error_status_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // request taken this edge
  wire take = req_valid && req_ready;
  property p_rd_lat;
    take && !req.write |-> ##3 rsp_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_mem;
    take && req.write |=> mem_en && mem_we && mem_addr == $past(req.addr);
  endproperty
  a_wr_mem: assert property (p_wr_mem) else $error("write lost");
  property p_rd_mem;
    take && !req.write |=> mem_en && !mem_we && mem_addr == $past(req.addr);
  endproperty
  a_rd_mem: assert property (p_rd_mem) else $error("read lost");
  property p_fix;
    rsp_valid && rsp.corrected |-> mem_en && mem_we;
  endproperty
  a_fix: assert property (p_fix) else $error("no write back");
  property p_cnt;
    rsp_valid && rsp.corrected && $past(corr_count) != 16'hffff
      |-> corr_count == $past(corr_count) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count not bumped");
  property p_irq;
    corr_irq |-> $past(corr_count) == corr_threshold
      && corr_count == corr_threshold + 16'h0001;
  endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
  property p_nmi;
    rsp_valid && rsp.err |-> nmi && error_status_pin;
  endproperty
  a_nmi: assert property (p_nmi) else $error("fatal not flagged");
  property p_pin;
    error_status_pin && !error_clear |=> error_status_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("error pin dropped");
endmodule : sram_wrapper_ecc_parity_props
bind sram_wrapper_ecc_parity sram_wrapper_ecc_parity_props props_u (
  .clock, .srst, .corr_threshold, .error_clear, .req_valid, .req,
  .req_ready, .rsp_valid, .rsp, .mem_en, .mem_we, .mem_addr,
  .corr_count, .corr_irq, .nmi, .error_status_pin);

// file: testbench/sram_mem_model.sv
// synchronous sram behind the wrapper, with read fault injection
`timescale 1ns/1ps
module sram_mem_model
  import sram_ecc_pkg::*;
(
  input wire logic clock,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic [11:0] mem_addr,
  input wire mem_word_t mem_wdata,
  input wire logic [21:0] flip,
  output mem_word_t mem_rdata
);
  mem_word_t ram [0:4095];
  mem_word_t rd_q = '0;
  assign mem_rdata = rd_q;
  // read data lasts one cycle, then toggles so stale data is never seen
  always @(posedge clock) begin
    if (mem_en && mem_we) ram[mem_addr] <= mem_wdata;
    if (mem_en && !mem_we) rd_q <= ram[mem_addr] ^ flip;
    else rd_q <= ~rd_q;
  end
endmodule : sram_mem_model

// file: testbench/sram_wrapper_ecc_parity_test.sv
// self-checking bench for the sram integrity wrapper
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module sram_wrapper_ecc_parity_test;
  import sram_ecc_pkg::*;
  logic clock = 0, srst = 1, ecc_mode = 1, count_clear = 0;
  logic error_clear = 0, req_valid = 0, req_ready, rsp_valid, mem_en;
  logic mem_we, corr_irq, nmi, error_status_pin, err;
  logic [15:0] corr_threshold = 16'h0001, corr_count, d;
  logic [11:0] mem_addr;
  logic [21:0] flip = '0;
  logic [1:0] k;
  req_t req = '0;
  rsp_t rsp, e;
  mem_word_t mem_wdata, mem_rdata;
  rsp_t exp_q[$];
  int n_mismatch = 0, cmp_count = 0, n_irq = 0, n_nmi = 0, b;
  int seed = 77864;
  sram_wrapper_ecc_parity dut_u (.clock(clock), .srst(srst),
    .ecc_mode(ecc_mode), .corr_threshold(corr_threshold),
    .count_clear(count_clear), .error_clear(error_clear),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .mem_en(mem_en), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .corr_count(corr_count), .corr_irq(corr_irq), .nmi(nmi),
    .error_status_pin(error_status_pin));
  sram_mem_model mem_u (.clock(clock), .mem_en(mem_en), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .flip(flip),
    .mem_rdata(mem_rdata));
  initial forever #12.5 clock = ~clock;
  // answers are paired with the oldest expectation
  always @(negedge clock) begin
    if (corr_irq === 1'b1) n_irq++;
    if (nmi === 1'b1) n_nmi++;
    if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("rsp", e, rsp)
    end
  end
  // one request, waits until the wrapper is ready again
  task automatic op(input logic w, s, input logic [11:0] a,
    input logic [15:0] v, input rsp_t x);
    while (req_ready !== 1'b1) @(negedge clock);
    req = '{w, s, a, v};
    req_valid = 1;
    if (!w) exp_q.push_back(x);
    @(negedge clock);
    req_valid = 0;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
  endtask : op
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // clean, single, double and scrubbed single faults in both modes
  initial begin
    repeat (12) @(negedge clock);
    srst = 0;
    `CHK("ready", 1'b1, req_ready)
    for (int i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      k = i[1:0];
      ecc_mode = (i < 8);
      b = $unsigned($random(seed)) % (ecc_mode ? 21 : 16);
      flip = k == 2 ? 22'h030000 : k[0] ? 22'h1 << b : 22'h0;
      op(1, 0, i[11:0], d, '0);
      err = k != 0 && (k == 2 || !ecc_mode);
      op(0, k == 3, i[11:0], 0,
        '{err ? d ^ flip[15:0] : d, err, !err && k != 0});
      flip = '0;
      if (k[0] && ecc_mode) op(0, 0, i[11:0], 0, '{d, 1'b0, 1'b0});
    end
    // let the monitor count the last answer before the totals
    repeat (2) @(negedge clock);
    `CHK("count", 16'h0004, corr_count)
    `CHK("irq", 1, n_irq)
    `CHK("nmi", 5, n_nmi)
    `CHK("pin", 1'b1, error_status_pin)
    count_clear = 1;
    error_clear = 1;
    @(negedge clock);
    count_clear = 0;
    error_clear = 0;
    `CHK("clr", 17'h0, {error_status_pin, corr_count})
    // threshold moved at run time: first fix now raises the interrupt
    corr_threshold = 16'h0000;
    ecc_mode = 1;
    flip = 22'h1 << b;
    op(1, 0, 12'h0ff, d, '0);
    op(0, 1, 12'h0ff, 0, '{d, 1'b0, 1'b1});
    flip = '0;
    repeat (2) @(negedge clock);
    `CHK("irq2", 2, n_irq)
    `CHK("count2", 16'h0001, corr_count)
    end_of_test;
  end
  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
endmodule : sram_wrapper_ecc_parity_test
